// ---- verilog/amlr_pkg.sv ----
// Purpose: Shared constants and types for the alert mask and low-bit register bank
// Assumes: Eight-bit register map reached through the device's serial register port
// Notes: Offsets, field positions and reset values live here only
package amlr_pkg;
	localparam logic [7:0] AMLR_ADDR_CONFIG_TWO = 8'h73;
	localparam logic [7:0] AMLR_ADDR_MASK_ONE = 8'h74;
	localparam logic [7:0] AMLR_ADDR_MASK_TWO = 8'h75;
	localparam logic [7:0] AMLR_ADDR_LOW_BITS = 8'h76;
	localparam logic [7:0] AMLR_RESET_VALUE = 8'h00;
	localparam int AMLR_NUM_VOLT = 4;
	localparam int AMLR_RESULT_W = 10;
	localparam int AMLR_LSB_W = 2;
	localparam int AMLR_NUM_CHAN = 8;
	// Config two fields
	localparam int AMLR_C2_RESERVED = 7;
	localparam int AMLR_C2_SINGLE = 6;
	localparam int AMLR_C2_DETECT_LO = 1;
	localparam int AMLR_C2_DETECT_HI = 3;
	localparam logic [7:0] AMLR_C2_WRITE_MASK = 8'h71;
	localparam logic [7:0] AMLR_C2_DETECT_MASK = 8'h0E;
	// Mask one fields
	localparam int AMLR_M1_OVERRIDE = 7;
	// Mask two fields
	localparam logic [7:0] AMLR_M2_WRITE_MASK = 8'hFD;
	localparam logic [7:0] AMLR_M2_ALL_SET = 8'hFF;
	localparam logic [7:0] AMLR_ALL_CHANNELS = 8'hFF;
	localparam logic [7:0] AMLR_ONE_HOT_BASE = 8'h01;
	localparam logic [3:0] AMLR_ALL_PENDING = 4'hF;
	localparam logic [3:0] AMLR_NONE_PENDING = 4'h0;

	typedef struct packed {
		logic [7:0] addr;
		logic wr_en;
		logic rd_en;
		logic [7:0] wdata;
	} amlr_req_t;

	typedef struct packed {
		logic [6:0] status_one;
		logic [7:0] status_two;
	} amlr_events_t;
endpackage

// ---- verilog/amlr_result_hold.sv ----
// Purpose: Holds one 10-bit conversion result, frozen on request
// Assumes: load pulses once per completed conversion
// Notes: A load that arrives while frozen is dropped
`timescale 1ns/1ns
`default_nettype none
module amlr_result_hold
	import amlr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic freeze,
	input wire logic [AMLR_RESULT_W-1:0] data,
	output logic [AMLR_RESULT_W-1:0] value_q
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= '0;
		end else if (load && !freeze) begin
			value_q <= data;
		end
	end
endmodule // amlr_result_hold
`default_nettype wire

// ---- verilog/amlr_bank.sv ----
// Purpose: Config two, alert masks, low-bit register and alert output
// Assumes: One register request per cycle; read data valid the cycle after rd_en
// Notes: Upper-byte reads of the four voltage readings arrive as upper_read pulses
// Functional notes
// - In single-channel mode only the channel named by the 3-bit select code is converted.
// - The single-channel bit makes the converter read one input, code 000 being 2.5 V.
// - While global_lock is high, writes to config two are ignored.
// - Mask one bits 0 to 6 each block out-of-limit events of their channel from the alert.
// - Mask one bit 7 decides if second-status events alert when all mask two bits are set.
// - Mask two bit 0 masks the 12 V or voltage-ID bit five event.
// - Mask two bit 1 masks overtemperature events and is read-only.
// - Mask two bits 2 to 4 mask fan one to fan three faults.
// - Mask two bit 5 masks the multi-function pin event.
// - Mask two bits 6 and 7 mask the remote diode faults.
// - The low-bit register holds the two LSBs of the four 10-bit voltage readings.
// - Reading the low-bit register freezes it and the upper bytes until those are read.
// - Config two, both masks and the low-bit register reset to zero.
`timescale 1ns/1ns
`default_nettype none
module amlr_bank
	import amlr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire amlr_req_t req,
	output logic [7:0] rdata_q,
	input wire logic global_lock,
	input wire logic [2:0] channel_select,
	input wire logic [2:0] fan_detect,
	input wire amlr_events_t events,
	input wire logic [AMLR_NUM_VOLT-1:0] single_channel_convert_done,
	input wire logic [AMLR_NUM_VOLT*AMLR_RESULT_W-1:0] single_channel_convert_data,
	input wire logic [AMLR_NUM_VOLT-1:0] upper_read,
	output logic [AMLR_NUM_VOLT*8-1:0] upper_bytes_q,
	output logic [AMLR_NUM_CHAN-1:0] channel_enable_q,
	output logic frozen_q,
	output logic alert_n_q
);
	logic [7:0] config_two_q;
	logic [7:0] alert_mask_one_q;
	logic [7:0] alert_mask_two_q;
	logic [3:0] pending_q;
	logic [AMLR_NUM_VOLT*AMLR_RESULT_W-1:0] held;
	logic [7:0] voltage_low_bits;
	logic [7:0] config_two_view;
	logic alert_d;
	logic low_read;
	logic hold_freeze;
	logic m2_all_set;

	assign low_read = req.rd_en && (req.addr == AMLR_ADDR_LOW_BITS);
	assign hold_freeze = frozen_q || low_read;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_two_q <= AMLR_RESET_VALUE;
		end else if (req.wr_en && req.addr == AMLR_ADDR_CONFIG_TWO && !global_lock) begin
			config_two_q <= req.wdata & AMLR_C2_WRITE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_mask_one_q <= AMLR_RESET_VALUE;
		end else if (req.wr_en && req.addr == AMLR_ADDR_MASK_ONE) begin
			alert_mask_one_q <= req.wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_mask_two_q <= AMLR_RESET_VALUE;
		end else if (req.wr_en && req.addr == AMLR_ADDR_MASK_TWO) begin
			alert_mask_two_q <= req.wdata & AMLR_M2_WRITE_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= AMLR_NONE_PENDING;
		end else if (low_read) begin
			pending_q <= AMLR_ALL_PENDING;
		end else begin
			pending_q <= pending_q & ~upper_read;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			frozen_q <= 1'b0;
		end else begin
			frozen_q <= low_read || ((pending_q & ~upper_read) != AMLR_NONE_PENDING);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < AMLR_NUM_VOLT; gi++) begin : g_volt
			amlr_result_hold u_hold (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.load(single_channel_convert_done[gi]),
				.freeze(hold_freeze),
				.data(single_channel_convert_data[gi*AMLR_RESULT_W +: AMLR_RESULT_W]),
				.value_q(held[gi*AMLR_RESULT_W +: AMLR_RESULT_W])
			);
			assign voltage_low_bits[gi*AMLR_LSB_W +: AMLR_LSB_W] =
				held[gi*AMLR_RESULT_W +: AMLR_LSB_W];
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					upper_bytes_q[gi*8 +: 8] <= AMLR_RESET_VALUE;
				end else begin
					upper_bytes_q[gi*8 +: 8] <=
						held[gi*AMLR_RESULT_W + AMLR_LSB_W +: 8];
				end
			end
			a_upper_consistent: assert property (
				@(posedge core_clk) disable iff (!rst_n)
				frozen_q |-> upper_bytes_q[gi*8 +: 8]
				== held[gi*AMLR_RESULT_W + AMLR_LSB_W +: 8])
				else $error("upper byte differs from held value");
			a_result_loads: assert property (
				@(posedge core_clk) disable iff (!rst_n)
				single_channel_convert_done[gi] && !hold_freeze
				|=> held[gi*AMLR_RESULT_W +: AMLR_RESULT_W]
				== $past(single_channel_convert_data[gi*AMLR_RESULT_W +: AMLR_RESULT_W]))
				else $error("result not taken while unfrozen");
		end
	endgenerate

	always_comb begin
		config_two_view = config_two_q;
		config_two_view[AMLR_C2_DETECT_HI:AMLR_C2_DETECT_LO] = fan_detect;
	end

	// Register read mux
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= AMLR_RESET_VALUE;
		end else if (req.rd_en) begin
			unique case (req.addr)
				AMLR_ADDR_CONFIG_TWO: rdata_q <= config_two_view;
				AMLR_ADDR_MASK_ONE: rdata_q <= alert_mask_one_q;
				AMLR_ADDR_MASK_TWO: rdata_q <= alert_mask_two_q;
				AMLR_ADDR_LOW_BITS: rdata_q <= voltage_low_bits;
				default: rdata_q <= AMLR_RESET_VALUE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_enable_q <= AMLR_ALL_CHANNELS;
		end else if (config_two_q[AMLR_C2_SINGLE]) begin
			channel_enable_q <= AMLR_ONE_HOT_BASE << channel_select;
		end else begin
			channel_enable_q <= AMLR_ALL_CHANNELS;
		end
	end

	assign m2_all_set = (alert_mask_two_q | ~AMLR_M2_WRITE_MASK) == AMLR_M2_ALL_SET;

	always_comb begin
		alert_d = ((events.status_one & ~alert_mask_one_q[6:0]) != 7'h00)
			|| ((events.status_two & ~alert_mask_two_q) != 8'h00);
		if (events.status_two != 8'h00 && m2_all_set
			&& !alert_mask_one_q[AMLR_M1_OVERRIDE]) begin
			alert_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_n_q <= 1'b1;
		end else begin
			alert_n_q <= !alert_d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_lock_blocks_write: assert property (
		req.wr_en && req.addr == AMLR_ADDR_CONFIG_TWO && global_lock
		|=> $stable(config_two_q)) else $error("config two changed under lock");
	a_reserved_stays_zero: assert property (
		!config_two_q[AMLR_C2_RESERVED]) else $error("reserved bit set");
	a_overtemp_mask_ro: assert property (
		!alert_mask_two_q[1]) else $error("overtemp mask bit writable");
	a_mask_one_store: assert property (
		req.wr_en && req.addr == AMLR_ADDR_MASK_ONE |=> alert_mask_one_q == $past(req.wdata))
		else $error("mask one not stored");
	a_single_channel: assert property (
		config_two_q[AMLR_C2_SINGLE] && $stable(channel_select) && $stable(config_two_q)
		|=> channel_enable_q == (AMLR_ONE_HOT_BASE << $past(channel_select)))
		else $error("wrong channel enabled");
	a_freeze_on_read: assert property (
		low_read |=> frozen_q) else $error("no freeze after low-bit read");
	a_frozen_stable: assert property (
		frozen_q |=> $stable(held)) else $error("held value moved while frozen");
	a_alert_unmasked: assert property (
		(events.status_one & ~alert_mask_one_q[6:0]) != 7'h00 |=> !alert_n_q)
		else $error("unmasked event without alert");
	a_override_quiet: assert property (
		events.status_one == 7'h00 && m2_all_set && alert_mask_one_q[AMLR_M1_OVERRIDE]
		&& (events.status_two & ~alert_mask_two_q) == 8'h00 |=> alert_n_q)
		else $error("alert despite override");
	a_fan_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h04
		&& alert_mask_two_q[2] && alert_mask_one_q[AMLR_M1_OVERRIDE] |=> alert_n_q)
		else $error("masked fan fault alerted");

	a_c2_write_lands: assert property (
		req.wr_en && req.addr == AMLR_ADDR_CONFIG_TWO && !global_lock
		|=> config_two_q == ($past(req.wdata) & AMLR_C2_WRITE_MASK))
		else $error("config two write lost while unlocked");
	a_c2_reads_reserved: assert property (
		req.rd_en && req.addr == AMLR_ADDR_CONFIG_TWO
		|=> !rdata_q[AMLR_C2_RESERVED])
		else $error("reserved bit read back set");
	a_all_channels: assert property (
		!config_two_q[AMLR_C2_SINGLE]
		|=> channel_enable_q == AMLR_ALL_CHANNELS)
		else $error("channel left out in normal mode");
	a_reset_zero: assert property (
		!$past(rst_n)
		|-> config_two_q == AMLR_RESET_VALUE && alert_mask_one_q == AMLR_RESET_VALUE
		&& alert_mask_two_q == AMLR_RESET_VALUE && voltage_low_bits == AMLR_RESET_VALUE)
		else $error("register not zero after reset");

	a_mask_two_store: assert property (
		req.wr_en && req.addr == AMLR_ADDR_MASK_TWO
		|=> alert_mask_two_q == ($past(req.wdata) & AMLR_M2_WRITE_MASK))
		else $error("mask two not stored");
	a_twelve_volt_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h01
		&& alert_mask_two_q[0] && alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> alert_n_q)
		else $error("masked 12 V event alerted");
	a_fan_three_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h10
		&& alert_mask_two_q[4] && alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> alert_n_q)
		else $error("masked fan three fault alerted");
	a_pin_multi_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h20
		&& alert_mask_two_q[5] && alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> alert_n_q)
		else $error("masked multi-function pin event alerted");
	a_diode_one_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h40
		&& alert_mask_two_q[6] && alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> alert_n_q)
		else $error("masked diode one fault alerted");
	a_diode_two_masked: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h80
		&& alert_mask_two_q[7] && alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> alert_n_q)
		else $error("masked diode two fault alerted");

	a_override_alert: assert property (
		events.status_two != 8'h00 && m2_all_set && !alert_mask_one_q[AMLR_M1_OVERRIDE]
		|=> !alert_n_q)
		else $error("override cleared but no alert");
	a_unmasked_two: assert property (
		(events.status_two & ~alert_mask_two_q) != 8'h00 |=> !alert_n_q)
		else $error("unmasked second-status event without alert");
	a_no_event_quiet: assert property (
		events.status_one == 7'h00 && events.status_two == 8'h00 |=> alert_n_q)
		else $error("alert without event");

	a_low_bits_read: assert property (
		low_read |=> rdata_q == {$past(held[31:30]), $past(held[21:20]),
		$past(held[11:10]), $past(held[1:0])})
		else $error("low bits out of place");
	a_idle_not_frozen: assert property (
		!frozen_q && !low_read |=> !frozen_q)
		else $error("freeze without low-bit read");

	c_single_mode: cover property (config_two_q[AMLR_C2_SINGLE] ##1 channel_enable_q != AMLR_ALL_CHANNELS);
	c_freeze_release: cover property (frozen_q ##[1:20] !frozen_q);
	c_alert_fires: cover property (alert_n_q ##1 !alert_n_q);
	c_locked_write: cover property (global_lock && req.wr_en && req.addr == AMLR_ADDR_CONFIG_TWO);
	c_override_quiet: cover property (events.status_two != 8'h00 && m2_all_set
		&& alert_mask_one_q[AMLR_M1_OVERRIDE]);
endmodule // amlr_bank
`default_nettype wire

// ---- tb/amlr_host_model.sv ----
// Purpose: Host on the register port of the bank
// Assumes: Requests launched just after a rising edge
// Notes: Read data taken one edge after the edge that takes the read
`timescale 1ns/1ns
`default_nettype none
module amlr_host_model
	import amlr_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] rdata_q,
	output var amlr_req_t req
);
	initial begin
		req = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wr_en: 1'b1, rd_en: 1'b0, wdata: d};
		@(posedge core_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
		d = rdata_q;
	endtask
endmodule // amlr_host_model
`default_nettype wire

// ---- tb/test_alert_mask_and_lsb_regs.sv ----
// Purpose: Self-checking bench for the alert mask and low-bit bank
// Assumes: Host model drives the register port
// Notes: Expected values come from a small model of the bank
`timescale 1ns/1ns
`default_nettype none
module test_alert_mask_and_lsb_regs
	import amlr_pkg::*;
;
	logic core_clk, rst_n, global_lock, frozen_q, alert_n_q, ea;
	logic [2:0] channel_select, fan_detect;
	amlr_events_t events;
	logic [3:0] single_channel_convert_done, upper_read;
	logic [39:0] single_channel_convert_data, dat, hd;
	amlr_req_t req;
	logic [7:0] rdata_q, channel_enable_q, rv, m1, m2, s2;
	logic [31:0] upper_bytes_q;
	logic [31:0] seed = 32'd35;
	logic [6:0] s1;
	int num_errors = 0;
	int comparisons = 0;
	amlr_bank amlr_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q),
		.global_lock(global_lock), .channel_select(channel_select), .fan_detect(fan_detect),
		.events(events), .single_channel_convert_done(single_channel_convert_done), .single_channel_convert_data(single_channel_convert_data), .upper_read(upper_read),
		.upper_bytes_q(upper_bytes_q), .channel_enable_q(channel_enable_q),
		.frozen_q(frozen_q), .alert_n_q(alert_n_q));
	amlr_host_model amlr_host_model_inst (.core_clk(core_clk), .rdata_q(rdata_q), .req(req));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] upr(input logic [39:0] d);
		for (int c = 0; c < 4; c++) upr[c*8+:8] = d[c*10+2+:8];
	endfunction
	function automatic logic [7:0] lsb(input logic [39:0] d);
		for (int c = 0; c < 4; c++) lsb[c*2+:2] = d[c*10+:2];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		amlr_host_model_inst.rd(a, rv);
		chk(rv, exp);
	endtask
	task automatic single_channel_convert();
		seed = xs(seed);
		dat[31:0] = seed;
		seed = xs(seed);
		dat[39:32] = seed[7:0];
		@(posedge core_clk);
		single_channel_convert_done <= 4'hF;
		single_channel_convert_data <= dat;
		@(posedge core_clk);
		single_channel_convert_done <= 4'h0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic unfreeze();
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			upper_read <= 4'h1 << ((k * 3) & 3);
		end
		@(posedge core_clk);
		upper_read <= 4'h0;
		for (int w = 0; w < 8 && frozen_q !== 1'b0; w++) @(posedge core_clk);
		if (frozen_q !== 1'b0) begin
			num_errors++;
			final_report();
		end
		repeat (2) @(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		rst_n = 1'b0;
		global_lock = 1'b0;
		channel_select = 3'h0;
		fan_detect = 3'h5;
		events = '0;
		single_channel_convert_done = 4'h0;
		upper_read = 4'h0;
		single_channel_convert_data = '0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 8'h73; a <= 8'h77; a++) begin
			if (a != 8'h76) rdchk(a[7:0], (a == 8'h73) ? 8'h0A : 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			channel_select <= i[2:0];
			amlr_host_model_inst.wr(AMLR_ADDR_CONFIG_TWO, 8'hC0);
			repeat (2) @(posedge core_clk);
			chk(channel_enable_q, AMLR_ONE_HOT_BASE << i);
		end
		rdchk(AMLR_ADDR_CONFIG_TWO, 8'h4A);
		global_lock <= 1'b1;
		amlr_host_model_inst.wr(AMLR_ADDR_CONFIG_TWO, 8'h00);
		rdchk(AMLR_ADDR_CONFIG_TWO, 8'h4A);
		global_lock <= 1'b0;
		amlr_host_model_inst.wr(AMLR_ADDR_CONFIG_TWO, 8'h00);
		repeat (2) @(posedge core_clk);
		chk(channel_enable_q, AMLR_ALL_CHANNELS);
		$display("config test done");
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			m1 = seed[7:0];
			m2 = (i % 4 == 0) ? 8'hFF : seed[15:8];
			s1 = seed[22:16];
			s2 = seed[31:24] & {8{seed[23]}};
			events <= '{status_one: s1, status_two: s2};
			amlr_host_model_inst.wr(AMLR_ADDR_MASK_ONE, m1);
			amlr_host_model_inst.wr(AMLR_ADDR_MASK_TWO, m2);
			m2 = m2 & 8'hFD;
			ea = |(s1 & ~m1[6:0]) | |(s2 & ~m2) | (s2 != 0 && m2 == 8'hFD && !m1[7]);
			repeat (2) @(posedge core_clk);
			chk(alert_n_q, !ea);
			rdchk(AMLR_ADDR_MASK_ONE, m1);
			rdchk(AMLR_ADDR_MASK_TWO, m2);
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rdchk(AMLR_ADDR_MASK_ONE, 8'h00);
		rdchk(AMLR_ADDR_MASK_TWO, 8'h00);
		events <= '{status_one: 7'h00, status_two: 8'h04};
		amlr_host_model_inst.wr(AMLR_ADDR_MASK_ONE, 8'h00);
		amlr_host_model_inst.wr(AMLR_ADDR_MASK_TWO, 8'hFF);
		repeat (2) @(posedge core_clk);
		chk(alert_n_q, 1'b0);
		amlr_host_model_inst.wr(AMLR_ADDR_MASK_ONE, 8'h80);
		repeat (2) @(posedge core_clk);
		chk(alert_n_q, 1'b1);
		for (int b = 0; b < 8; b++) begin
			s2 = 8'h01 << b;
			events <= '{status_one: 7'h00, status_two: s2};
			amlr_host_model_inst.wr(AMLR_ADDR_MASK_TWO, s2);
			repeat (2) @(posedge core_clk);
			chk(alert_n_q, b != 1);
			amlr_host_model_inst.wr(AMLR_ADDR_MASK_TWO, 8'h00);
			repeat (2) @(posedge core_clk);
			chk(alert_n_q, 1'b0);
		end
		$display("alert test done");
		rdchk(AMLR_ADDR_LOW_BITS, 8'h00);
		chk(frozen_q, 1'b1);
		single_channel_convert();
		unfreeze();
		chk(upper_bytes_q, 32'h0);
		single_channel_convert();
		rdchk(AMLR_ADDR_LOW_BITS, lsb(dat));
		m1 = lsb(dat);
		hd = dat;
		single_channel_convert();
		rdchk(AMLR_ADDR_LOW_BITS, m1);
		chk(upper_bytes_q, upr(hd));
		unfreeze();
		single_channel_convert();
		chk(upper_bytes_q, upr(dat));
		$display("freeze test done");
		final_report();
	end
endmodule // test_alert_mask_and_lsb_regs
`default_nettype wire
